/* dsp_top.sv */
// Dual synchronous serial port with an APB register slave.
// Assumes all inputs are synchronous to clk_i and pins are resolved outside.
`timescale 1ns/1ps
`include "dsp_map.svh"

module dsp_top
  import dsp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial pins, index 0 is the first port, index 1 the second.
  input  wire logic [1:0]  miso_i,
  output logic      [1:0]  miso_o,
  output logic      [1:0]  miso_oe_o,
  input  wire logic [1:0]  mosi_i,
  output logic      [1:0]  mosi_o,
  output logic      [1:0]  mosi_oe_o,
  input  wire logic [1:0]  sck_i,
  output logic      [1:0]  sck_o,
  output logic      [1:0]  sck_oe_o,
  input  wire logic [1:0]  ss_n_i,
  // Interrupt request of each port.
  output logic      [1:0]  irq_o
);

  // ************************************************************
  // Helper functions.
  // ************************************************************
  // Half of the serial clock period in bus clocks.
  function automatic logic [6:0] half_period(input logic [2:0] code);
    logic [7:0] div;
    div = 8'h00;
    case (code)
      3'h0:    div = {1'b0, `DSP_DIV_0};
      3'h1:    div = {1'b0, `DSP_DIV_1};
      3'h2:    div = {1'b0, `DSP_DIV_2};
      3'h3:    div = {1'b0, `DSP_DIV_3};
      3'h4:    div = {1'b0, `DSP_DIV_4};
      3'h5:    div = {1'b0, `DSP_DIV_5};
      3'h6:    div = {1'b0, `DSP_DIV_6};
      default: div = `DSP_DIV_7;
    endcase
    return div[7:1];
  endfunction : half_period

  // Bit that leaves the shifter next, given the bit order.
  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first_option);
    return lsb_first_option ? v[0] : v[7];
  endfunction : out_bit

  // Output enable of a pin that may be open-drain: only a low is driven.
  function automatic logic pin_oe(input logic drv, input logic val, input logic wom);
    return drv & (~wom | ~val);
  endfunction : pin_oe

  // ************************************************************
  // APB decode.
  // ************************************************************
  localparam logic [7:0] IDX_CTL [2] = '{`DSP_IDX_CTL1, `DSP_IDX_CTL2};
  localparam logic [7:0] IDX_STA [2] = '{`DSP_IDX_STA1, `DSP_IDX_STA2};
  localparam logic [7:0] IDX_DAT [2] = '{`DSP_IDX_DAT1, `DSP_IDX_DAT2};
  localparam logic [7:0] IDX_OPT [2] = '{`DSP_IDX_OPT1, `DSP_IDX_SYSTEM_OPTIONS_TWO};
  localparam logic [7:0] IDX_DIR [2] = '{`DSP_IDX_DIR1, `DSP_IDX_DIR2};

  logic [7:0]  idx;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        setup;
  logic [1:0]  hit;
  logic [7:0]  rd_val [2];
  logic [7:0]  rd_mux;
  logic [31:0] prdata_r;

  assign idx       = paddr_i[9:2];
  assign setup     = psel_i & ~penable_i;
  assign acc       = psel_i & penable_i;
  assign wr        = acc & pwrite_i;
  assign rd        = acc & ~pwrite_i;
  assign rd_mux    = rd_val[0] | rd_val[1];
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~|hit;
  assign prdata_o  = prdata_r;

  // Read data is caught in the setup cycle so it comes from a flop.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // ************************************************************
  // The two serial ports.
  // ************************************************************
  // Both ports replicated.
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:2]  ctl_r;
    logic [1:0]  rate_r;
    logic [1:0]  opt_r;
    logic [3:0]  dir_r;
    logic        done_r;
    logic        write_collision_flag_r;
    logic        mode_fault_flag_r;
    logic        done_arm_r;
    logic        write_collision_flag_arm_r;
    logic        mode_fault_flag_arm_r;
    logic [7:0]  sh_r;
    logic [7:0]  rx_r;
    logic        dout_r;
    dsp_xfer_e   st_r;
    logic        tog_r;
    logic [6:0]  hcnt_r;
    logic [3:0]  ecnt_r;
    logic [2:0]  bcnt_r;
    logic        sck_prev_r;

    logic        ie, serial_port_enable, wom, master_select, clock_polarity, clock_phase, lsb_first_option;
    logic [2:0]  rate;
    logic [6:0]  half;
    logic        hit_ctl, hit_sta, hit_dat, hit_opt, hit_dir;
    logic        wr_ctl, wr_dat, rd_dat, rd_sta, dat_acc;
    logic        inhibit, busy, load, write_collision_flag_set, start, mfault;
    logic        slave_sel, s_act, s_lead, s_trail;
    logic        tick, m_lead, m_trail, lead, trail, samp, drv;
    logic        din, m_done, s_done, done;
    logic [7:0]  nsh;
    logic [7:0]  status;

    assign ie   = ctl_r[`DSP_CTL_IE];
    assign serial_port_enable  = ctl_r[`DSP_CTL_SPE];
    assign wom  = ctl_r[`DSP_CTL_WOM];
    assign master_select = ctl_r[`DSP_CTL_MASTER_SELECT];
    assign clock_polarity = ctl_r[`DSP_CTL_CLOCK_POLARITY];
    assign clock_phase = ctl_r[`DSP_CTL_CLOCK_PHASE];
    assign lsb_first_option = opt_r[1];
    assign rate = {opt_r[0], rate_r};
    assign half = half_period(rate);

    assign hit_ctl = idx == IDX_CTL[p];
    assign hit_sta = idx == IDX_STA[p];
    assign hit_dat = idx == IDX_DAT[p];
    assign hit_opt = idx == IDX_OPT[p];
    assign hit_dir = idx == IDX_DIR[p];
    assign hit[p]  = hit_ctl | hit_sta | hit_dat | hit_opt | hit_dir;
    assign wr_ctl  = wr & hit_ctl;
    assign wr_dat  = wr & hit_dat;
    assign rd_dat  = rd & hit_dat;
    assign rd_sta  = rd & hit_sta;
    assign dat_acc = wr_dat | rd_dat;

    assign status = {done_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
    assign rd_val[p] = hit_ctl ? {ctl_r, rate_r} :
                       hit_sta ? status :
                       hit_dat ? rx_r :
                       hit_opt ? {4'h0, opt_r, 2'b00} :
                       hit_dir ? {2'b00, dir_r, 2'b00} : 8'h00;

    // Fault only while select pin is a dedicated input.
    assign mfault    = serial_port_enable & master_select & ~dir_r[`DSP_DIR_SS] & ~ss_n_i[p];
    assign slave_sel = serial_port_enable & ~master_select & ~ss_n_i[p];

    // Slave edges are taken from the incoming clock, seen only while selected.
    assign s_act   = sck_i[p] ^ clock_polarity;
    assign s_lead  = slave_sel & s_act & ~sck_prev_r;
    assign s_trail = slave_sel & ~s_act & sck_prev_r;

    assign tick    = (st_r == XF_MASTER) & (hcnt_r == 7'd1);
    assign m_lead  = tick & ~tog_r;
    assign m_trail = tick & tog_r;
    assign lead    = master_select ? m_lead : s_lead;
    assign trail   = master_select ? m_trail : s_trail;
    assign samp    = clock_phase ? trail : lead;
    assign drv     = clock_phase ? lead : trail;

    assign din = master_select ? miso_i[p] : mosi_i[p];
    assign nsh = lsb_first_option ? {din, sh_r[7:1]} : {sh_r[6:0], din};

    assign m_done = m_trail & (ecnt_r == 4'hF);
    assign s_done = ~master_select & samp & (bcnt_r == 3'h7);
    assign done   = m_done | s_done;

    // A phase-0 slave stays busy for as long as it is selected.
    assign busy     = (st_r != XF_IDLE) | (slave_sel & ~clock_phase);
    assign inhibit  = done_r & ~done_arm_r;
    assign load     = wr_dat & ~inhibit & ~busy;
    assign write_collision_flag_set = wr_dat & ~inhibit & busy;
    assign start    = load & serial_port_enable & master_select & ~mfault;

    // ************************************************************
    // Control, options and direction registers.
    // ************************************************************
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        ctl_r[7:2] <= `DSP_CTL_RST_HI;
        opt_r      <= `DSP_OPT_RST;
        dir_r      <= `DSP_DIR_RST;
      end else begin
        if (wr_ctl) begin
          ctl_r[7:2] <= pwdata_i[7:2];
        end
        if (wr & hit_opt) begin
          opt_r <= {pwdata_i[`DSP_OPT_LSB_FIRST_OPTION], pwdata_i[`DSP_OPT_RATE2]};
        end
        if (wr & hit_dir) begin
          dir_r <= pwdata_i[5:2];
        end
        if (mfault) begin
          ctl_r[`DSP_CTL_MASTER_SELECT] <= 1'b0;
          dir_r                <= 4'h0;
        end
      end
    end

    // The control register rate bits keep their value through reset.
    always_ff @(posedge clk_i) begin
      if (wr_ctl) begin
        rate_r <= pwdata_i[1:0];
      end
    end

    // ************************************************************
    // Status flags; a setting event always wins over a clear.
    // ************************************************************
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        done_r     <= 1'b0;
        write_collision_flag_r     <= 1'b0;
        mode_fault_flag_r     <= 1'b0;
        done_arm_r <= 1'b0;
        write_collision_flag_arm_r <= 1'b0;
        mode_fault_flag_arm_r <= 1'b0;
      end else begin
        // Done flag set; cleared by data access.
        done_r <= done | (done_r & ~(done_arm_r & dat_acc));
        write_collision_flag_r <= write_collision_flag_set | (write_collision_flag_r & ~(write_collision_flag_arm_r & dat_acc));
        // Fault flag cleared by control write.
        mode_fault_flag_r <= mfault | (mode_fault_flag_r & ~(mode_fault_flag_arm_r & wr_ctl));
        if (dat_acc) begin
          done_arm_r <= 1'b0;
          write_collision_flag_arm_r <= 1'b0;
        end else if (rd_sta) begin
          done_arm_r <= done_arm_r | prdata_r[`DSP_STA_DONE];
          write_collision_flag_arm_r <= write_collision_flag_arm_r | prdata_r[`DSP_STA_WRITE_COLLISION_FLAG];
        end
        if (wr_ctl) begin
          mode_fault_flag_arm_r <= 1'b0;
        end else if (rd_sta) begin
          mode_fault_flag_arm_r <= mode_fault_flag_arm_r | prdata_r[`DSP_STA_MODE_FAULT_FLAG];
        end
      end
    end

    // ************************************************************
    // Shifter and receive buffer.
    // ************************************************************
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        sh_r   <= 8'h00;
        rx_r   <= 8'h00;
        dout_r <= 1'b0;
      end else begin
        // Writes go straight to the shifter.
        if (load) begin
          sh_r <= pwdata_i[7:0];
        end else if (samp) begin
          sh_r <= nsh;
        end
        // An unread byte is kept; the newer one is lost.
        if (done && !done_r) begin
          rx_r <= samp ? nsh : sh_r;
        end
        if (load) begin
          dout_r <= out_bit(pwdata_i[7:0], lsb_first_option);
        end else if (drv || st_r == XF_IDLE) begin
          dout_r <= out_bit(sh_r, lsb_first_option);
        end
      end
    end

    // ************************************************************
    // Transfer sequencing and master clock generator.
    // ************************************************************
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        st_r       <= XF_IDLE;
        tog_r      <= 1'b0;
        hcnt_r     <= 7'd1;
        ecnt_r     <= 4'h0;
        bcnt_r     <= 3'h0;
        sck_prev_r <= 1'b0;
      end else begin
        sck_prev_r <= s_act;
        if (start || !slave_sel && !master_select) begin
          bcnt_r <= 3'h0;
        end else if (samp) begin
          bcnt_r <= bcnt_r + 3'h1;
        end
        case (st_r)
          XF_IDLE: begin
            tog_r  <= 1'b0;
            hcnt_r <= half;
            ecnt_r <= 4'h0;
            if (start) begin
              st_r <= XF_MASTER;
            end else if (slave_sel && (!clock_phase || s_lead)) begin
              st_r <= XF_SLAVE;
            end
          end
          XF_MASTER: begin
            // Disable or fault stops the clock.
            if (!serial_port_enable || mfault || m_done) begin
              st_r  <= XF_IDLE;
              tog_r <= 1'b0;
            end else if (tick) begin
              tog_r  <= ~tog_r;
              hcnt_r <= half;
              ecnt_r <= ecnt_r + 4'h1;
            end else begin
              hcnt_r <= hcnt_r - 7'd1;
            end
          end
          XF_SLAVE: begin
            if (!slave_sel || (clock_phase && s_done)) begin
              st_r <= XF_IDLE;
            end
          end
          default: begin
            st_r <= XF_IDLE;
          end
        endcase
      end
    end

    // ************************************************************
    // Pins and interrupt.
    // ************************************************************
    // Clock idles at polarity level.
    assign sck_o[p]     = (clock_polarity ^ tog_r) & ~wom;
    assign sck_oe_o[p]  = pin_oe(serial_port_enable & master_select & dir_r[2], clock_polarity ^ tog_r, wom);
    assign mosi_o[p]    = dout_r & ~wom;
    assign mosi_oe_o[p] = pin_oe(serial_port_enable & master_select & dir_r[1], dout_r, wom);
    // A deselected slave leaves its output released.
    assign miso_o[p]    = dout_r & ~wom;
    assign miso_oe_o[p] = pin_oe(slave_sel & dir_r[0], dout_r, wom);
    assign irq_o[p]     = ie & (done_r | mode_fault_flag_r);
  end : g_port

endmodule : dsp_top

/* dsp_map.svh */
// Register map, field positions, reset values and clock ratios of the dual serial port.
// Assumes a 32-bit APB slave where each register index is one aligned word.
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// ************************************************************
// Register indices; byte address is four times the index.
// ************************************************************
`define DSP_IDX_CTL1 8'h28
`define DSP_IDX_STA1 8'h29
`define DSP_IDX_DAT1 8'h2A
`define DSP_IDX_OPT1 8'h38
`define DSP_IDX_DIR1 8'h60
`define DSP_IDX_CTL2 8'h4C
`define DSP_IDX_STA2 8'h4D
`define DSP_IDX_DAT2 8'h4E
`define DSP_IDX_SYSTEM_OPTIONS_TWO 8'h4F
`define DSP_IDX_DIR2 8'h61

// ************************************************************
// Field positions.
// ************************************************************
`define DSP_CTL_IE    7
`define DSP_CTL_SPE   6
`define DSP_CTL_WOM   5
`define DSP_CTL_MASTER_SELECT  4
`define DSP_CTL_CLOCK_POLARITY  3
`define DSP_CTL_CLOCK_PHASE  2
`define DSP_STA_DONE  7
`define DSP_STA_WRITE_COLLISION_FLAG  6
`define DSP_STA_MODE_FAULT_FLAG  4
`define DSP_OPT_LSB_FIRST_OPTION  3
`define DSP_OPT_RATE2 2
`define DSP_DIR_SS    3

// ************************************************************
// Reset values.
// ************************************************************
`define DSP_CTL_RST_HI 6'h01
`define DSP_OPT_RST    2'h0
`define DSP_DIR_RST    4'h0

// ************************************************************
// Bus clock divide ratios by rate code.
// ************************************************************
`define DSP_DIV_0 7'd2
`define DSP_DIV_1 7'd4
`define DSP_DIV_2 7'd16
`define DSP_DIV_3 7'd32
`define DSP_DIV_4 7'd8
`define DSP_DIV_5 7'd16
`define DSP_DIV_6 7'd64
`define DSP_DIV_7 8'd128

`endif

/* dsp_pkg.sv */
// Types shared by the dual serial port design.
// Assumes the constants of dsp_map.svh are included by the design files.
package dsp_pkg;

  // ************************************************************
  // Transfer state of one port.
  // ************************************************************
  typedef enum logic [1:0] {
    XF_IDLE,
    XF_MASTER,
    XF_SLAVE
  } dsp_xfer_e;

endpackage : dsp_pkg

/* dsp_top_monitor.sv */
// Checker for the dual serial port, watching the top-level ports only.
// Assumes it is bound to dsp_top and that reset is synchronous, active low.
`timescale 1ns/1ps
`include "dsp_map.svh"
module dsp_monitor
  import dsp_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Pins and interrupts.
  input wire logic [1:0]  miso_oe_o,
  input wire logic [1:0]  mosi_oe_o,
  input wire logic [1:0]  sck_oe_o,
  input wire logic [1:0]  sck_o,
  input wire logic [1:0]  irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire [7:0] idx    = paddr_i[9:2];
  wire       acc    = psel_i & penable_i;
  wire       is_sta = (idx == `DSP_IDX_STA1) || (idx == `DSP_IDX_STA2);
  wire       is_opt = (idx == `DSP_IDX_OPT1) || (idx == `DSP_IDX_SYSTEM_OPTIONS_TWO);
  wire       is_ctl = (idx == `DSP_IDX_CTL1) || (idx == `DSP_IDX_CTL2);
  wire       is_dat = (idx == `DSP_IDX_DAT1) || (idx == `DSP_IDX_DAT2);
  wire       is_dir = (idx == `DSP_IDX_DIR1) || (idx == `DSP_IDX_DIR2);
  wire       mapped = is_sta || is_opt || is_ctl || is_dat || is_dir;
  // ****
  // Enable shadows; one cycle of delay covers outputs that lag a write.
  // ****
  logic [1:0] ie_r, spe_r, ie_d_r, spe_d_r;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ie_r    <= 2'b00;
      spe_r   <= 2'b00;
      ie_d_r  <= 2'b00;
      spe_d_r <= 2'b00;
    end else begin
      ie_d_r  <= ie_r;
      spe_d_r <= spe_r;
      if (acc && pwrite_i && is_ctl) begin
        ie_r[idx == `DSP_IDX_CTL2]  <= pwdata_i[7];
        spe_r[idx == `DSP_IDX_CTL2] <= pwdata_i[6];
      end
    end
  end
  sequence s_rd;
    psel_i && penable_i && !pwrite_i;
  endsequence
  property p_ready;
    acc |-> pready_o;
  endproperty
  property p_upper;
    s_rd |-> prdata_o[31:8] == 24'h000000;
  endproperty
  property p_slverr;
    pslverr_o == (acc && !mapped);
  endproperty
  property p_sta0;
    s_rd ##0 is_sta |-> prdata_o[5] == 1'b0 && prdata_o[3:0] == 4'h0;
  endproperty
  property p_opt0;
    s_rd ##0 is_opt |-> prdata_o[7:4] == 4'h0 && prdata_o[1:0] == 2'h0;
  endproperty
  property p_rst;
    $rose(reset_n_i) |-> (irq_o == 2'b00 && sck_oe_o == 2'b00 && sck_o == 2'b00) [*2];
  endproperty
  property p_off;
    (~spe_r & ~spe_d_r & (miso_oe_o | mosi_oe_o | sck_oe_o)) == 2'b00;
  endproperty
  property p_mask;
    (~ie_r & ~ie_d_r & irq_o) == 2'b00;
  endproperty
  a_ready:  assert property (p_ready)  else $error("pready low in access");
  a_upper:  assert property (p_upper)  else $error("read data upper bits set");
  a_slverr: assert property (p_slverr) else $error("slave error mismatch");
  a_sta0:   assert property (p_sta0)   else $error("unused status bit set");
  a_opt0:   assert property (p_opt0)   else $error("unused option bit set");
  a_rst:    assert property (p_rst)    else $error("outputs active after reset");
  a_off:    assert property (p_off)    else $error("pin driven while disabled");
  a_mask:   assert property (p_mask)   else $error("interrupt while disabled");
endmodule : dsp_monitor

bind dsp_top dsp_monitor u_mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .miso_oe_o(miso_oe_o),
  .mosi_oe_o(mosi_oe_o), .sck_oe_o(sck_oe_o), .sck_o(sck_o), .irq_o(irq_o)
);

/* dsp_peer.sv */
// Behavioural serial slave facing the first port of the dual serial port.
// Assumes the bench sets its mode to match the port before selecting it.
`timescale 1ns/1ps
module dsp_peer (
  // Serial lines.
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  output logic            miso_o,
  // Mode and data.
  input  wire logic       clock_polarity_i,
  input  wire logic       clock_phase_i,
  input  wire logic       lsb_first_option_i,
  input  wire logic [7:0] tx_i,
  output logic      [7:0] rx_o
);
  int n;
  function automatic int pos(input int k);
    return lsb_first_option_i ? k : 7 - k;
  endfunction : pos
  always @(negedge sel_n_i) begin
    n = 0;
    miso_o = tx_i[pos(0)];
  end
  always @(sck_i) begin
    if (!sel_n_i && n < 8) begin
      if ((sck_i != clock_polarity_i) != clock_phase_i) begin
        rx_o[pos(n)] = mosi_i;
        n = n + 1;
      end else begin
        miso_o = tx_i[pos(n)];
      end
    end
  end
  // A released line must not keep showing the last bit.
  always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule : dsp_peer

/* test_dual_spi_port_regs.sv */
// Self-checking bench for the dual serial port, with a peer on port one.
// Assumes the monitor is bound to the design and the peer is a slave.
`timescale 1ns/1ps
`include "dsp_map.svh"
module test_dual_spi_port_regs
  import dsp_pkg::*;
;
  logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [1:0]  ss_n_i;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, p_miso;
  wire  [1:0]  miso_o, miso_oe_o, mosi_o, mosi_oe_o, sck_o, sck_oe_o, irq_o;
  logic        p_sel_n, p_clock_polarity, p_clock_phase, p_lsb_first_option;
  logic [7:0]  p_tx;
  logic        s2_sck, s2_mosi;
  wire  [7:0]  p_rx;
  int          n_errors, n_checks;
  wire sck0  = sck_oe_o[0] ? sck_o[0] : p_clock_polarity;
  wire mosi0 = mosi_oe_o[0] ? mosi_o[0] : 1'b1;
  dsp_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .miso_i({1'b1, p_miso}), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .mosi_i({s2_mosi, mosi0}), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
    .sck_i({s2_sck, sck0}), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ss_n_i(ss_n_i), .irq_o(irq_o));
  dsp_peer peer (.sck_i(sck0), .mosi_i(mosi0), .sel_n_i(p_sel_n), .miso_o(p_miso),
    .clock_polarity_i(p_clock_polarity), .clock_phase_i(p_clock_phase), .lsb_first_option_i(p_lsb_first_option), .tx_i(p_tx), .rx_o(p_rx));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task summarize;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d,
           output logic [7:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'b00, i, 2'b00};
    pwdata_i <= {24'h000000, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      n_errors++;
      summarize();
    end
    r = prdata_o[7:0];
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask : wr
  task rc(input logic [7:0] i, input logic [7:0] x, input logic [7:0] m);
    logic [7:0] r;
    logic e;
    apb(1'b0, i, 8'h00, r, e);
    chk(r & m, x);
  endtask : rc
  // Counts serial clock toggles until the port raises its interrupt.
  task wait_irq(input int lim, output int c, output int t);
    logic s;
    s = sck_o[0];
    c = 0;
    t = 0;
    do begin
      @(negedge clk_i);
      c++;
      t += (sck_o[0] !== s);
      s = sck_o[0];
      if (c > lim) begin
        n_errors++;
        summarize();
      end
    end while (irq_o[0] !== 1'b1);
  endtask : wait_irq
  task quiet(input int p, output int t);
    logic s, o;
    s = sck_o[p];
    o = sck_oe_o[p];
    t = 0;
    repeat (30) begin
      @(negedge clk_i);
      t += (sck_o[p] !== s) + (sck_oe_o[p] !== o);
      s = sck_o[p];
    end
  endtask : quiet
  task s_regs;
    logic [7:0] r;
    logic e;
    rc(`DSP_IDX_CTL1, 8'h04, 8'hFC);
    rc(`DSP_IDX_STA1, 8'h00, 8'hFF);
    rc(`DSP_IDX_OPT1, 8'h00, 8'h0C);
    rc(`DSP_IDX_CTL2, 8'h04, 8'hFC);
    rc(`DSP_IDX_STA2, 8'h00, 8'hFF);
    rc(`DSP_IDX_SYSTEM_OPTIONS_TWO, 8'h00, 8'hFF);
    wr(`DSP_IDX_SYSTEM_OPTIONS_TWO, 8'hFF);
    rc(`DSP_IDX_SYSTEM_OPTIONS_TWO, 8'h0C, 8'hFF);
    wr(`DSP_IDX_SYSTEM_OPTIONS_TWO, 8'h00);
    apb(1'b0, 8'h30, 8'h00, r, e);
    chk({7'h00, e}, 8'h01);
  endtask : s_regs
  task s_xfer(input logic [2:0] r);
    int dv[8] = '{2, 4, 16, 32, 8, 16, 64, 128};
    int c, t, d;
    logic [7:0] tx;
    d = dv[r];
    tx = 8'h96 + r;
    p_clock_polarity <= r[0];
    p_clock_phase <= r[1];
    p_lsb_first_option <= r[1] ^ r[2];
    p_tx <= 8'h3C ^ {r, r, 2'b01};
    wr(`DSP_IDX_DIR1, 8'h18);
    wr(`DSP_IDX_OPT1, {4'h0, r[1] ^ r[2], r[2], 2'b00});
    wr(`DSP_IDX_CTL1, {4'hD, r[0], r[1], r[1:0]});
    @(negedge clk_i);
    chk({7'h00, sck_o[0]}, {7'h00, r[0]});
    p_sel_n <= 1'b0;
    wr(`DSP_IDX_DAT1, tx);
    wait_irq(9 * d + 20, c, t);
    chk(8'(t), 8'd16);
    chk({7'h00, c >= 8 * d && c <= 8 * d + 6}, 8'h01);
    chk(p_rx, tx);
    rc(`DSP_IDX_STA1, 8'h80, 8'hFF);
    rc(`DSP_IDX_DAT1, p_tx, 8'hFF);
    rc(`DSP_IDX_STA1, 8'h00, 8'hFF);
    p_sel_n <= 1'b1;
  endtask : s_xfer
  task s_block;
    int c, t;
    wr(`DSP_IDX_OPT1, 8'h00);
    wr(`DSP_IDX_CTL1, 8'hD0);
    p_clock_polarity <= 1'b0;
    p_clock_phase <= 1'b0;
    p_lsb_first_option <= 1'b0;
    p_tx <= 8'h5A;
    p_sel_n <= 1'b0;
    wr(`DSP_IDX_DAT1, 8'hC3);
    wait_irq(40, c, t);
    wr(`DSP_IDX_DAT1, 8'h11);
    quiet(0, t);
    chk(8'(t), 8'd0);
    rc(`DSP_IDX_STA1, 8'h80, 8'hFF);
    p_sel_n <= 1'b1;
    @(posedge clk_i);
    p_sel_n <= 1'b0;
    wr(`DSP_IDX_DAT1, 8'h3C);
    wait_irq(40, c, t);
    chk(p_rx, 8'h3C);
    rc(`DSP_IDX_STA1, 8'h80, 8'hFF);
    rc(`DSP_IDX_DAT1, 8'h5A, 8'hFF);
    p_sel_n <= 1'b1;
  endtask : s_block
  task s_collide;
    int c, t;
    wr(`DSP_IDX_CTL1, 8'hD2);
    p_tx <= 8'hA5;
    p_sel_n <= 1'b0;
    wr(`DSP_IDX_DAT1, 8'hE7);
    wr(`DSP_IDX_DAT1, 8'h18);
    rc(`DSP_IDX_STA1, 8'h40, 8'hFF);
    wait_irq(200, c, t);
    chk(p_rx, 8'hE7);
    rc(`DSP_IDX_STA1, 8'hC0, 8'hFF);
    rc(`DSP_IDX_DAT1, 8'hA5, 8'hFF);
    rc(`DSP_IDX_STA1, 8'h00, 8'hFF);
    p_sel_n <= 1'b1;
  endtask : s_collide
  task ss_pulse;
    @(posedge clk_i);
    ss_n_i[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    ss_n_i[0] <= 1'b1;
  endtask : ss_pulse
  task s_fault;
    wr(`DSP_IDX_CTL1, 8'h50);
    ss_pulse();
    @(negedge clk_i);
    chk({7'h00, irq_o[0]}, 8'h00);
    rc(`DSP_IDX_STA1, 8'h10, 8'hFF);
    rc(`DSP_IDX_CTL1, 8'h40, 8'hFC);
    rc(`DSP_IDX_DIR1, 8'h00, 8'h3C);
    wr(`DSP_IDX_CTL1, 8'hD0);
    rc(`DSP_IDX_STA1, 8'h00, 8'hFF);
    ss_pulse();
    @(negedge clk_i);
    chk({7'h00, irq_o[0]}, 8'h01);
    rc(`DSP_IDX_STA1, 8'h10, 8'hFF);
    wr(`DSP_IDX_CTL1, 8'h40);
    rc(`DSP_IDX_STA1, 8'h00, 8'hFF);
  endtask : s_fault
  task s_slave;
    int t;
    logic [7:0] x, m;
    x = 8'h77;
    m = 8'hA6;
    wr(`DSP_IDX_CTL2, 8'h40);
    wr(`DSP_IDX_DIR2, 8'h14);
    wr(`DSP_IDX_DAT2, x);
    quiet(1, t);
    chk(8'(t), 8'd0);
    chk({7'h00, sck_oe_o[1]}, 8'h00);
    rc(`DSP_IDX_STA2, 8'h00, 8'hFF);
    ss_n_i[1] <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      @(posedge clk_i);
      s2_mosi <= m[k];
      @(negedge clk_i);
      chk({6'h00, miso_oe_o[1], miso_o[1]}, {6'h00, 1'b1, x[k]});
      @(posedge clk_i);
      s2_sck <= 1'b1;
      repeat (3) @(posedge clk_i);
      s2_sck <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    rc(`DSP_IDX_STA2, 8'h80, 8'hFF);
    rc(`DSP_IDX_DAT2, m, 8'hFF);
    ss_n_i[1] <= 1'b1;
    wr(`DSP_IDX_CTL2, 8'h70);
    @(negedge clk_i);
    chk({6'h00, sck_oe_o[1], sck_o[1]}, 8'h02);
    wr(`DSP_IDX_CTL2, 8'h78);
    @(negedge clk_i);
    chk({6'h00, sck_oe_o[1], sck_o[1]}, 8'h00);
  endtask : s_slave
  initial begin
    reset_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    ss_n_i = 2'b11;
    p_sel_n = 1'b1;
    p_clock_polarity = 1'b0;
    p_clock_phase = 1'b0;
    p_lsb_first_option = 1'b0;
    p_tx = 8'h00;
    s2_sck = 1'b0;
    s2_mosi = 1'b1;
    n_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    s_regs();
    for (int r = 0; r < 8; r++) s_xfer(r[2:0]);
    s_block();
    s_collide();
    s_fault();
    s_slave();
    summarize();
  end
endmodule : test_dual_spi_port_regs
